/* File: verilog/ecpp_pkg.sv */
package ecpp_pkg;
  // ------------------------------------------------------------
  // port word and register offsets
  // ------------------------------------------------------------
  localparam int PORT_WORD_W = 8;
  localparam int ADDR_W = 11;
  localparam logic [10:0] OFS_DATA = 11'h000;
  localparam logic [10:0] OFS_STATUS = 11'h001;
  localparam logic [10:0] OFS_CONTROL = 11'h002;
  localparam logic [10:0] OFS_QUEUE = 11'h400;
  localparam logic [10:0] OFS_INFO_B = 11'h401;
  localparam logic [10:0] OFS_EXT_CTRL = 11'h402;
  // ------------------------------------------------------------
  // mode field codes
  // ------------------------------------------------------------
  localparam logic [2:0] MODE_STD = 3'h0;
  localparam logic [2:0] MODE_BIDIR = 3'h1;
  localparam logic [2:0] MODE_COMPAT = 3'h2;
  localparam logic [2:0] MODE_ECP = 3'h3;
  localparam logic [2:0] MODE_EPP = 3'h4;
  localparam logic [2:0] MODE_RSVD = 3'h5;
  localparam logic [2:0] MODE_TEST = 3'h6;
  localparam logic [2:0] MODE_CONFIG = 3'h7;
  // ------------------------------------------------------------
  // field positions and reset values
  // ------------------------------------------------------------
  localparam int CTL_STROBE = 0;
  localparam int CTL_AUTOFD = 1;
  localparam int CTL_INIT = 2;
  localparam int CTL_SELIN = 3;
  localparam int CTL_ACKIE = 4;
  localparam int CTL_DIR = 5;
  localparam int EXT_SVC = 2;
  localparam int EXT_DMA = 3;
  localparam int EXT_FAULT_OFF = 4;
  localparam int CMD_ADDR_BIT = 7;
  localparam logic [5:0] CTL_RESET = 6'h00;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [7:0] INFO_A_VALUE = 8'h10;
  localparam logic [2:0] MODE_RESET = MODE_STD;
  // ------------------------------------------------------------
  // queue and timing
  // ------------------------------------------------------------
  localparam int QUEUE_DEPTH = 16;
  localparam int QUEUE_W = 9;
  localparam int SVC_THRESHOLD = 8;
  localparam int CLK_PERIOD_NS = 10;
  localparam int STROBE_NS = 500;
  localparam int STROBE_CYC = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // ------------------------------------------------------------
  // carriers
  // ------------------------------------------------------------
  typedef struct packed {
    logic rd;
    logic wr;
    logic dmaAck;
    logic [10:0] addr;
    logic [7:0] wdata;
  } ecpp_bus_t;
  typedef struct packed {
    logic busy;
    logic nAck;
    logic pError;
    logic select;
    logic nFault;
    logic [7:0] pdIn;
  } ecpp_pin_in_t;
  typedef struct packed {
    logic nStrobe;
    logic nAutoFd;
    logic nInit;
    logic nSelectIn;
    logic [7:0] pdOut;
    logic pdOe;
  } ecpp_pin_out_t;
  typedef enum logic [2:0] {
    LK_IDLE, LK_SETUP, LK_STROBE, LK_RELEASE, LK_REQ, LK_TAKE, LK_REPEAT
  } ecpp_link_t;
endpackage

/* File: verilog/ecpp_port.sv */
`timescale 1ns/10ps
// How it works
// RULE1: every register and queue access is eight bits
// RULE2: status and control reachable in every mode
// RULE3: all queue views share one 16-byte store
// RULE4: standard modes behave as plain printer port
// RULE5: no negotiation; DMA burst both directions
// RULE6: compatibility queue strobes bytes out automatically
// RULE7: reverse count byte repeats next byte
// RULE8: forward compression is absent, flag reads zero
// RULE9: strobe clocks bytes, interlocked with busy
// RULE10: data lines carry address, data or count
// RULE11: peripheral drops busy when ready again
// RULE12: peripheral busy marks reverse command bytes
// RULE13: peripheral asserts ack for valid reverse data
// RULE14: host ack requests and throttles reverse bytes
// RULE15: forward host ack marks command versus data
// RULE16: init low means reverse, high forward
// RULE17: peripheral acknowledges reverse with error line low
// RULE18: drive data only after peripheral releases bus
// RULE19: peripheral drives bus only in reverse phase
// RULE20: fault input raises error interrupt, forward only
// RULE21: fault request is hint; host picks direction
// RULE22: three-bit mode field selects port behaviour
// RULE23: command queue writes tagged, forward only
// RULE24: command bit7 set address, clear count
// RULE25: full queue rejects writes; full, empty shown

module ecpp_queue #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic flush,
  // fill side
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  // drain side
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData,
  output logic [$clog2(DEPTH+1)-1:0] count
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH+1);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [CW-1:0] cnt;
  } ecpp_q_t;
  ecpp_q_t st, next_st;
  logic doPush, doPop;

  assign inReady = (st.cnt != CW'(DEPTH));
  assign outValid = (st.cnt != '0);
  assign outData = st.mem[st.rp];
  assign count = st.cnt;
  assign doPush = inValid && inReady; // [RULE25]
  assign doPop = outValid && outReady;

  always_comb begin
    next_st = st;
    if (doPush) begin
      next_st.mem[st.wp] = inData;
      next_st.wp = (st.wp == AW'(DEPTH-1)) ? '0 : AW'(st.wp + 1'b1);
    end
    if (doPop) begin
      next_st.rp = (st.rp == AW'(DEPTH-1)) ? '0 : AW'(st.rp + 1'b1);
    end
    if (doPush && !doPop) begin
      next_st.cnt = CW'(st.cnt + 1'b1);
    end else if (doPop && !doPush) begin
      next_st.cnt = CW'(st.cnt - 1'b1);
    end
    if (flush) begin
      next_st.wp = '0;
      next_st.rp = '0;
      next_st.cnt = '0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
endmodule

module ecpp_port #(
  parameter int DEPTH = ecpp_pkg::QUEUE_DEPTH,
  parameter int THRESHOLD = ecpp_pkg::SVC_THRESHOLD,
  parameter int STROBE_CYCLES = ecpp_pkg::STROBE_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // host register port
  input wire ecpp_pkg::ecpp_bus_t bus,
  output logic [7:0] rdata,
  output logic dmaReq,
  output logic faultIrq,
  // printer link
  input wire ecpp_pkg::ecpp_pin_in_t pins,
  output ecpp_pkg::ecpp_pin_out_t pinOut
);
  import ecpp_pkg::*;
  localparam int CW = $clog2(DEPTH+1);

  typedef struct packed {
    logic [5:0] ctl;
    logic [7:0] dataLatch;
    logic [2:0] mode;
    logic faultOff;
    logic transferEngineEnable;
    logic serviceReq;
    logic [7:0] rdata;
    logic [7:0] lastByte;
    ecpp_link_t link;
    logic [7:0] linkByte;
    logic linkCmd;
    logic [6:0] rleCount;
    logic [7:0] strobeCnt;
  } ecpp_state_t;
  ecpp_state_t st, next_st;

  logic fInValid, fInReady, fOutValid, fOutReady, flush;
  logic [QUEUE_W-1:0] fInData, fOutData;
  logic [CW-1:0] fCount;
  logic dir, queueMode, isEcp, isCompat, atQueue;
  logic cmdWr, hostPush, hostPop, linkPush, linkPop;

  // ------------------------------------------------------------
  // shared queue
  // ------------------------------------------------------------
  ecpp_queue #(.WIDTH(QUEUE_W), .DEPTH(DEPTH)) u_queue ( // [RULE3]
    .clk(clk),
    .rst(rst),
    .flush(flush),
    .inValid(fInValid),
    .inReady(fInReady),
    .inData(fInData),
    .outValid(fOutValid),
    .outReady(fOutReady),
    .outData(fOutData),
    .count(fCount)
  );

  // ------------------------------------------------------------
  // mode decode
  // ------------------------------------------------------------
  assign isEcp = (st.mode == MODE_ECP); // [RULE22]
  assign isCompat = (st.mode == MODE_COMPAT);
  assign queueMode = isEcp || isCompat || (st.mode == MODE_TEST);
  // standard and compatibility modes are always forward
  assign dir = (st.mode == MODE_STD || isCompat) ? 1'b0 : st.ctl[CTL_DIR]; // [RULE22]
  assign atQueue = bus.dmaAck || (bus.addr == OFS_QUEUE);
  assign cmdWr = bus.wr && !bus.dmaAck && bus.addr == OFS_DATA && isEcp && !dir; // [RULE23]
  assign hostPush = cmdWr || (bus.wr && queueMode && atQueue // [RULE1]
                    && (st.mode == MODE_TEST || !dir));
  assign hostPop = bus.rd && queueMode && atQueue && (st.mode == MODE_TEST || (isEcp && dir));
  assign linkPush = (st.link == LK_REPEAT);
  assign linkPop = (st.link == LK_IDLE) && fOutValid && !dir
                   && (isCompat || (isEcp && pins.pError)); // [RULE18]
  assign fInValid = hostPush || linkPush;
  assign fInData = hostPush ? {cmdWr, bus.wdata} : {1'b0, st.linkByte}; // [RULE23]
  assign fOutReady = hostPop || linkPop;
  assign flush = bus.wr && bus.addr == OFS_EXT_CTRL && !bus.dmaAck
                 && (bus.wdata[7:5] == MODE_STD || bus.wdata[7:5] == MODE_BIDIR);

  // ------------------------------------------------------------
  // registers and link sequencer
  // ------------------------------------------------------------
  always_comb begin
    next_st = st;
    if (bus.wr && !bus.dmaAck) begin
      case (bus.addr)
        OFS_DATA: begin
          if (!isEcp) begin
            next_st.dataLatch = bus.wdata; // [RULE4]
          end
        end
        OFS_CONTROL: begin
          next_st.ctl = bus.wdata[5:0]; // [RULE2]
        end
        OFS_EXT_CTRL: begin
          next_st.mode = bus.wdata[7:5]; // [RULE22]
          next_st.faultOff = bus.wdata[EXT_FAULT_OFF];
          next_st.transferEngineEnable = bus.wdata[EXT_DMA];
          next_st.serviceReq = bus.wdata[EXT_SVC];
        end
        default: begin
        end
      endcase
    end
    // threshold set wins over a software clear in the same cycle
    if (st.transferEngineEnable && queueMode && ((!dir && fCount <= CW'(THRESHOLD))
        || (dir && fCount >= CW'(THRESHOLD)))) begin
      next_st.serviceReq = 1'b1;
    end
    if (bus.rd) begin
      next_st.rdata = 8'h00;
      if (bus.dmaAck || (bus.addr == OFS_QUEUE && queueMode)) begin
        // an empty read repeats the previous byte
        next_st.rdata = fOutValid ? fOutData[7:0] : st.lastByte;
      end else begin
        case (bus.addr)
          OFS_DATA: next_st.rdata = isEcp ? 8'h00 : pins.pdIn; // [RULE4]
          OFS_STATUS: next_st.rdata = {!pins.busy, pins.nAck, pins.pError, pins.select,
                                       pins.nFault, 3'h0}; // [RULE2]
          OFS_CONTROL: next_st.rdata = {2'h0, st.ctl}; // [RULE2]
          OFS_QUEUE: next_st.rdata = (st.mode == MODE_CONFIG) ? INFO_A_VALUE : 8'h00;
          // compression bit stays zero: no forward encoder
          OFS_INFO_B: next_st.rdata = (st.mode == MODE_CONFIG) ?
                                      {1'b0, faultIrq, 6'h00} : 8'h00; // [RULE8]
          OFS_EXT_CTRL: next_st.rdata = {st.mode, st.faultOff, st.transferEngineEnable,
                                         st.serviceReq, !fInReady, !fOutValid}; // [RULE25]
          default: next_st.rdata = 8'h00;
        endcase
      end
    end
    if (hostPop && fOutValid) begin
      next_st.lastByte = fOutData[7:0];
    end
    case (st.link)
      LK_IDLE: begin
        next_st.strobeCnt = 8'h00;
        if (linkPop) begin
          next_st.linkByte = fOutData[7:0]; // [RULE10]
          next_st.linkCmd = fOutData[8];
          next_st.link = LK_SETUP;
        end else if (isEcp && dir && !pins.pError && fInReady) begin // [RULE17]
          next_st.link = LK_REQ;
        end
      end
      LK_SETUP: begin
        if (!pins.busy) begin // [RULE11]
          next_st.link = LK_STROBE; // [RULE9]
        end
      end
      LK_STROBE: begin
        next_st.strobeCnt = 8'(st.strobeCnt + 1'b1);
        if (isCompat && st.strobeCnt >= 8'(STROBE_CYCLES - 1)) begin
          next_st.link = LK_RELEASE; // [RULE6]
        end else if (isEcp && pins.busy) begin
          next_st.link = LK_RELEASE; // [RULE9]
        end
      end
      LK_RELEASE: begin
        next_st.link = LK_IDLE;
      end
      LK_REQ: begin
        if (!pins.nAck) begin // [RULE13]
          next_st.linkByte = pins.pdIn;
          next_st.linkCmd = !pins.busy; // [RULE12]
          next_st.link = LK_TAKE;
        end
      end
      LK_TAKE: begin
        if (pins.nAck) begin
          if (!st.linkCmd) begin
            next_st.link = LK_REPEAT;
          end else begin
            // channel addresses have no consumer here and are dropped
            if (!st.linkByte[CMD_ADDR_BIT]) begin
              next_st.rleCount = st.linkByte[6:0]; // [RULE7] [RULE24]
            end
            next_st.link = LK_IDLE;
          end
        end
      end
      LK_REPEAT: begin
        if (fInReady) begin
          if (st.rleCount == 7'h00) begin
            next_st.link = LK_IDLE;
          end else begin
            next_st.rleCount = 7'(st.rleCount - 1'b1); // [RULE7]
          end
        end
      end
      default: begin
        next_st.link = LK_IDLE;
      end
    endcase
    if (!isEcp && !isCompat) begin
      next_st.link = LK_IDLE;
      next_st.rleCount = 7'h00;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st <= '{ctl: CTL_RESET, dataLatch: DATA_RESET, mode: MODE_RESET, link: LK_IDLE,
              default: '0};
    end else begin
      st <= next_st;
    end
  end

  // ------------------------------------------------------------
  // pins and host outputs
  // ------------------------------------------------------------
  always_comb begin
    pinOut.nStrobe = !st.ctl[CTL_STROBE]; // [RULE4]
    pinOut.nAutoFd = !st.ctl[CTL_AUTOFD];
    pinOut.nInit = st.ctl[CTL_INIT];
    pinOut.nSelectIn = !st.ctl[CTL_SELIN];
    pinOut.pdOut = st.dataLatch;
    pinOut.pdOe = !dir;
    if (isCompat || isEcp) begin
      pinOut.nStrobe = (st.link != LK_STROBE); // [RULE9]
      pinOut.pdOut = st.linkByte;
    end
    if (isEcp) begin
      pinOut.nInit = !dir; // [RULE16]
      pinOut.pdOe = !dir && pins.pError; // [RULE18] [RULE19]
      if (dir) begin
        pinOut.nAutoFd = (st.link != LK_REQ); // [RULE14]
      end else if (st.link == LK_SETUP || st.link == LK_STROBE || st.link == LK_RELEASE) begin
        pinOut.nAutoFd = !st.linkCmd; // [RULE15]
      end else begin
        pinOut.nAutoFd = 1'b1;
      end
    end
  end

  assign rdata = st.rdata;
  assign dmaReq = st.transferEngineEnable && !st.serviceReq && queueMode // [RULE5]
                  && (dir ? fOutValid : fInReady);
  // a fault request is only reported; direction stays with software
  assign faultIrq = (isEcp || isCompat) && !dir && !st.faultOff && !pins.nFault; // [RULE20] [RULE21]

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_setup_ready;
    st.link == LK_SETUP && !pins.busy;
  endsequence
  sequence s_rev_taken;
    st.link == LK_REQ && !pins.nAck;
  endsequence

  a_bus_release: assert property (isEcp && dir |-> !pinOut.pdOe) // [RULE18]
    else $error("data lines driven in reverse");
  a_init_dir: assert property (isEcp |-> pinOut.nInit == !dir) // [RULE16]
    else $error("init pin does not follow direction");
  a_strobe_interlock: assert property (s_setup_ready ##1 (isEcp && !pins.busy) // [RULE9]
    |-> !pinOut.nStrobe)
    else $error("strobe not asserted after busy low");
  a_hostack_cmd: assert property (isEcp && !dir && st.link == LK_STROBE // [RULE15]
    |-> pinOut.nAutoFd == !st.linkCmd)
    else $error("host ack does not mark command");
  a_rev_request: assert property (s_rev_taken |=> st.link == LK_TAKE && pinOut.nAutoFd) // [RULE14]
    else $error("host ack not released after peripheral ack");
  a_rle_count: assert property (st.link == LK_TAKE && pins.nAck && st.linkCmd // [RULE7]
    && !st.linkByte[7] |=> st.rleCount == $past(st.linkByte[6:0]))
    else $error("count byte not captured");
  a_full_reject: assert property (!fInReady && !fOutReady && !flush |=> !fInReady) // [RULE25]
    else $error("full queue changed without a drain");
  a_ctrl_write: assert property (bus.wr && !bus.dmaAck && bus.addr == OFS_CONTROL // [RULE2]
    |=> st.ctl == $past(bus.wdata[5:0]))
    else $error("control write lost");
  a_fault_irq: assert property (isEcp && !dir && !st.faultOff && !pins.nFault // [RULE20]
    |-> faultIrq)
    else $error("fault not reported");
  a_compat_strobe: assert property (isCompat && $fell(pinOut.nStrobe) // [RULE6]
    |-> (!isCompat || !pinOut.nStrobe) [*2])
    else $error("compat strobe too short");
endmodule

/* File: bench/ecpp_peer_model.sv */
`timescale 1ns/10ps
module ecpp_peer_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // link pins
  input wire ecpp_pkg::ecpp_pin_out_t pinOut,
  output ecpp_pkg::ecpp_pin_in_t pins,
  // bench side
  input wire logic stall,
  input wire logic nFaultIn,
  input wire logic revValid,
  input wire logic revCmd,
  input wire logic [7:0] revByte,
  output logic revTaken,
  output logic got,
  output logic gotCmd,
  output logic [7:0] gotData
);
  import ecpp_pkg::*;
  logic busy;
  logic nAck;
  logic pError;
  logic drive;
  logic [7:0] drvByte;
  logic [7:0] lastByte;
  logic [7:0] lineLevel;
  // released lines show the inverse of the last level, never a stale copy
  assign lineLevel = pinOut.pdOe ? pinOut.pdOut : (drive ? drvByte : ~lastByte);
  assign pins = {busy, nAck, pError, 1'b1, nFaultIn, lineLevel};
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      busy <= 1'b0;
      nAck <= 1'b1;
      pError <= 1'b0;
      drive <= 1'b0;
      drvByte <= 8'h00;
      lastByte <= 8'h00;
      revTaken <= 1'b0;
      got <= 1'b0;
      gotCmd <= 1'b0;
      gotData <= 8'h00;
    end else begin
      lastByte <= lineLevel;
      pError <= pinOut.nInit;
      got <= 1'b0;
      revTaken <= 1'b0;
      if (pinOut.nInit) begin
        if (!pinOut.nStrobe && !busy && !stall) begin
          busy <= 1'b1;
          got <= 1'b1;
          gotData <= pinOut.pdOut;
          gotCmd <= !pinOut.nAutoFd;
        end else if (pinOut.nStrobe && busy && !stall) begin
          busy <= 1'b0;
        end
      end else if (nAck && revValid && !pinOut.nAutoFd && !pError && pinOut.nSelectIn) begin
        drive <= 1'b1;
        drvByte <= revByte;
        busy <= !revCmd;
        nAck <= 1'b0;
        revTaken <= 1'b1;
      end else if (!nAck && pinOut.nAutoFd) begin
        nAck <= 1'b1;
        drive <= 1'b0;
      end
    end
  end
endmodule

/* File: bench/ecp_parallel_port_test.sv */
`timescale 1ns/10ps
module ecp_parallel_port_test;
  import ecpp_pkg::*;
  // ------------------------------------------------------------
  // signals and instances
  // ------------------------------------------------------------
  logic clk = 1'b0;
  logic rst = 1'b1;
  ecpp_bus_t bus = '0;
  logic [7:0] rdata;
  logic dmaReq;
  logic faultIrq;
  ecpp_pin_in_t pins;
  ecpp_pin_out_t pinOut;
  logic stall = 1'b0;
  logic nFaultIn = 1'b1;
  logic revValid = 1'b0;
  logic revCmd = 1'b0;
  logic [7:0] revByte = 8'h00;
  logic revTaken;
  logic got;
  logic gotCmd;
  logic [7:0] gotData;
  logic [31:0] seed = 32'h0000_dc0b;
  logic [8:0] rxq[$];
  int errTotal = 0;
  int totalChecks = 0;
  always #5 clk = ~clk;
  ecpp_port #(.STROBE_CYCLES(3)) dut_u (.clk(clk), .rst(rst), .bus(bus), .rdata(rdata),
    .dmaReq(dmaReq), .faultIrq(faultIrq), .pins(pins), .pinOut(pinOut));
  ecpp_peer_model peer_u (.clk(clk), .rst(rst), .pinOut(pinOut), .pins(pins), .stall(stall),
    .nFaultIn(nFaultIn), .revValid(revValid), .revCmd(revCmd), .revByte(revByte),
    .revTaken(revTaken), .got(got), .gotCmd(gotCmd), .gotData(gotData));
  always @(posedge clk) begin
    if (got === 1'b1) rxq.push_back({gotCmd, gotData});
  end
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  task automatic rnd(output logic [7:0] v);
    seed = xorshift(seed);
    v = seed[7:0];
  endtask
  function automatic logic [7:0] statusExp(input ecpp_pin_in_t p);
    return {!p.busy, p.nAck, p.pError, p.select, p.nFault, 3'h0};
  endfunction
  function automatic logic [3:0] ctlPins(input logic [7:0] c);
    return {~c[0], ~c[1], c[2], ~c[3]};
  endfunction
  task automatic check(input logic [8:0] seen, input logic [8:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      errTotal++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic completeRun();
    $display("checks %0d mismatches %0d", totalChecks, errTotal);
    if (errTotal == 0 && totalChecks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic wr(input logic [10:0] a, input logic [7:0] d);
    @(posedge clk);
    bus.wr <= 1'b1;
    bus.addr <= a;
    bus.wdata <= d;
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask
  task automatic rdChk(input logic [10:0] a, input logic [7:0] exp);
    @(posedge clk);
    bus.rd <= 1'b1;
    bus.addr <= a;
    @(posedge clk);
    bus.rd <= 1'b0;
    @(posedge clk);
    #1 check({1'b0, rdata}, {1'b0, exp});
  endtask
  task automatic settle();
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic setMode(input logic [2:0] m);
    wr(OFS_EXT_CTRL, {MODE_STD, 5'h00});
    wr(OFS_EXT_CTRL, {m, 5'h00});
  endtask
  task automatic waitRx(input int n);
    int i;
    for (i = 0; i < 2000 && rxq.size() < n; i++) @(posedge clk);
    if (rxq.size() < n) begin
      errTotal++;
      completeRun();
    end
  endtask
  initial begin
    repeat (90000) @(posedge clk);
    errTotal++;
    completeRun();
  end
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  initial begin
    logic [7:0] v;
    logic [7:0] c;
    logic [8:0] expq[$];
    logic [8:0] revTab[5];
    int i;
    int k;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    rdChk(OFS_CONTROL, 8'h00);
    rdChk(OFS_EXT_CTRL, 8'h01);
    check({pinOut.nStrobe, pinOut.nAutoFd, pinOut.nInit, pinOut.nSelectIn}, ctlPins(8'h00));
    for (i = 0; i < 4; i++) begin
      rnd(c);
      rnd(v);
      nFaultIn <= c[6];
      wr(OFS_CONTROL, c);
      wr(OFS_DATA, v);
      rdChk(OFS_CONTROL, {2'b00, c[5:0]});
      check({pinOut.nStrobe, pinOut.nAutoFd, pinOut.nInit, pinOut.nSelectIn}, ctlPins(c));
      check({pinOut.pdOe, pinOut.pdOut}, {1'b1, v});
      rdChk(OFS_DATA, v);
      rdChk(OFS_STATUS, statusExp(pins));
    end
    // bidirectional mode honours the direction bit
    setMode(MODE_BIDIR);
    wr(OFS_CONTROL, 8'h20);
    settle();
    check({pinOut.pdOe, pinOut.nInit}, 2'b00);
    nFaultIn <= 1'b1;
    setMode(MODE_CONFIG);
    rdChk(OFS_QUEUE, INFO_A_VALUE);
    rdChk(OFS_INFO_B, 8'h00);
    // forward burst against a stalled peer, until the store refuses
    wr(OFS_CONTROL, 8'h04);
    setMode(MODE_ECP);
    rxq.delete();
    stall <= 1'b1;
    wr(OFS_DATA, 8'h85);
    wr(OFS_DATA, 8'h05);
    expq = '{9'h185, 9'h105};
    for (i = 0; i < 16; i++) begin
      rnd(v);
      wr(OFS_QUEUE, v);
      if (i < 15) expq.push_back({1'b0, v});
    end
    rdChk(OFS_EXT_CTRL, {MODE_ECP, 5'h02});
    check({pinOut.nAutoFd, pinOut.pdOut}, 9'h085);
    stall <= 1'b0;
    waitRx(17);
    for (i = 0; i < 17; i++) check(rxq[i], expq[i]);
    rdChk(OFS_EXT_CTRL, {MODE_ECP, 5'h01});
    nFaultIn <= 1'b0;
    settle();
    check({faultIrq, pinOut.nInit}, 2'b11);
    rdChk(OFS_STATUS, statusExp(pins));
    wr(OFS_EXT_CTRL, {MODE_ECP, 5'h10});
    settle();
    check(faultIrq, 1'b0);
    wr(OFS_EXT_CTRL, {MODE_ECP, 5'h08});
    rdChk(OFS_EXT_CTRL, {MODE_ECP, 5'h0d});
    check(dmaReq, 1'b0);
    // reverse burst with a run-length count and a dropped address
    wr(OFS_CONTROL, 8'h24);
    wr(OFS_EXT_CTRL, {MODE_ECP, 5'h08});
    settle();
    check({faultIrq, pinOut.nInit, pinOut.pdOe}, 3'b000);
    nFaultIn <= 1'b1;
    rnd(v);
    rnd(c);
    revTab = '{9'h103, {1'b0, v}, {1'b0, c}, 9'h181, 9'h05a};
    expq = '{{1'b0, v}, {1'b0, v}, {1'b0, v}, {1'b0, v}, {1'b0, c}, 9'h05a};
    for (i = 0; i < 5; i++) begin
      @(posedge clk);
      revValid <= 1'b1;
      revCmd <= revTab[i][8];
      revByte <= revTab[i][7:0];
      for (k = 0; k < 200 && revTaken !== 1'b1; k++) @(posedge clk);
      if (revTaken !== 1'b1) begin
        errTotal++;
        completeRun();
      end
      revValid <= 1'b0;
    end
    repeat (4) @(posedge clk);
    for (k = 0; k < 100 && !(pinOut.nAutoFd === 1'b0 && pins.nAck === 1'b1); k++) @(posedge clk);
    if (k == 100) begin
      errTotal++;
      completeRun();
    end
    #1 check(dmaReq, 1'b1);
    bus.dmaAck <= 1'b1;
    for (i = 0; i < 6; i++) rdChk(OFS_DATA, expq[i][7:0]);
    bus.dmaAck <= 1'b0;
    rdChk(OFS_EXT_CTRL, {MODE_ECP, 5'h09});
    check(dmaReq, 1'b0);
    // compatibility queue strobes out unaided
    wr(OFS_CONTROL, 8'h04);
    setMode(MODE_COMPAT);
    rxq.delete();
    expq.delete();
    for (i = 0; i < 3; i++) begin
      rnd(v);
      wr(OFS_QUEUE, v);
      expq.push_back({1'b0, v});
    end
    waitRx(3);
    for (i = 0; i < 3; i++) check(rxq[i], expq[i]);
    // loopback view of the shared store, then flush on mode change
    setMode(MODE_TEST);
    rnd(v);
    rnd(c);
    bus.dmaAck <= 1'b1;
    wr(OFS_DATA, v);
    bus.dmaAck <= 1'b0;
    wr(OFS_QUEUE, c);
    rdChk(OFS_QUEUE, v);
    rdChk(OFS_QUEUE, c);
    rdChk(OFS_QUEUE, c);
    wr(OFS_QUEUE, v);
    setMode(MODE_STD);
    rdChk(OFS_EXT_CTRL, 8'h01);
    completeRun();
  end
endmodule
